// >>> verilog/sspt_pkg.sv
// Constants, field positions and state types of the two-wire serial port.
// Assumes a 32-bit APB register window with one aligned word per register.
package sspt_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_BUF  = 8'h00;
    localparam logic [7:0] OFS_CON1 = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_CON2 = 8'h0c;
    localparam logic [7:0] OFS_ADDR = 8'h10;
    localparam logic [7:0] OFS_PIR  = 8'h14;
    localparam logic [7:0] OFS_PIE  = 8'h18;
    localparam logic [7:0] OFS_IPR  = 8'h1c;

    // ****************************************
    // Field positions and codes
    // ****************************************
    localparam int C2_GCEN  = 7;
    localparam int C2_ACKST = 6;
    localparam int C2_ACKDT = 5;
    localparam int C2_ACK_SEQUENCE_REQUEST = 4;
    localparam int C2_RECEIVE_REQUEST  = 3;
    localparam int C2_PEN   = 2;
    localparam int C2_RESTART_REQUEST  = 1;
    localparam int C2_SEN   = 0;
    localparam int PIR_PORT = 3;
    localparam logic [3:0] MODE_S7   = 4'h6;
    localparam logic [3:0] MODE_S10  = 4'h7;
    localparam logic [3:0] MODE_MST  = 4'h8;
    localparam logic [3:0] MODE_FWM  = 4'hb;
    localparam logic [3:0] MODE_S7I  = 4'he;
    localparam logic [3:0] MODE_S10I = 4'hf;
    localparam logic [4:0] TEN_HDR   = 5'h1e;
    localparam logic [6:0] GEN_CALL  = 7'h00;
    localparam logic [3:0] LAST_BIT  = 4'h7;
    localparam logic [3:0] ACK_BIT   = 4'h8;
    localparam logic [3:0] END_BIT   = 4'h9;
    localparam logic       BUS_IDLE  = 1'b1;

    typedef enum logic [2:0] {
        M_IDLE, M_START, M_RSTART, M_TX, M_RX, M_ACK, M_STOP
    } sspt_mst_t;

    // All state of the port except the pin synchronisers; every field but the pin history resets to zero
    typedef struct packed {
        logic [7:0] buf_r;
        logic [7:0] sr;
        logic [7:0] addr;
        logic [7:0] con2;
        logic [7:0] pie;
        logic [7:0] ipr;
        logic [7:0] rd;
        logic       write_collision, ov, en, clock_polarity;
        logic [3:0] mode;
        logic       slew_select, cke, da, p, s, rw, ua, bf, pirf;
        logic [3:0] bitc;
        logic [1:0] ph;
        logic [6:0] brg;
        sspt_mst_t  ms;
        logic       msl, mdl, sdl;
        logic       lis, sact, stx, th, sclp, sdap;
    } sspt_core_t;

endpackage

// >>> verilog/sspt_core.sv
// Two-wire serial port: APB registers, slave and hardware-master engines.
// Assumes open-drain SCL/SDA resolved outside, pins asynchronous to clk,
// and a sleep level from the power controller on the same clock.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// - Slave shift logic runs from bus clock; eighth bit of a received byte sets flag and may wake.
// - Sleep freezes master transfer; it resumes from the frozen state.
// - In idle states the peripheral clock keeps running, so transfers continue.
// - Enabled completion event wakes the controller when a master transfer ends.
// - Reset disables the port and aborts any transfer.
// - Shift modes map to polarity/edge bits: 00=0,1 01=0,0 10=1,1 11=1,0.
// - Master, slave, general call, start/stop interrupts, 7- and 10-bit addresses.
// - Address register holds own address, or baud reload in its low seven bits.
// - Received byte moves from shift register to buffer and sets flag.
// - Writing the buffer loads buffer and shift register together.
// - Controls read/write; status low six bits read-only, top two read/write.
// - Status bit 7 selects slew control.
// - Status bit 6 enables bus-specific input thresholds.
// - Slave status bit 5 shows data (1) or address (0) last.
// - Status bits 4/3 show last stop/start; cleared by reset and disable.
// - Bit 2: slave read direction of last match; master transmit in progress.
// - Bit 2 ORed with the request bits shows the port is busy.
// - Bit 1 asks software to rewrite the address in 10-bit slave mode.
// - Bit 0 shows buffer holds unsent or unread byte.
// - Mode field selects slave 7/10-bit, master, firmware master, irq slaves.
// - Write collision on buffer write during transfer; software clears it.
module sspt_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        sleep,
    output logic             wake,
    output logic             bus_active,
    output logic      [1:0]  shift_bus_mode
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic scl_m, scl_s, sda_m, sda_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_m <= sspt_pkg::BUS_IDLE;
            scl_s <= sspt_pkg::BUS_IDLE;
            sda_m <= sspt_pkg::BUS_IDLE;
            sda_s <= sspt_pkg::BUS_IDLE;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    sspt_pkg::sspt_core_t q, n;
    logic       wr, rd, setup, hit, slv, ten, sp_irq, mst, mbusy, tick;
    logic       rise, fall, start, stop;
    logic [7:0] wd, rmux;

    assign wd    = pwdata[7:0];
    assign wr    = psel & penable & pwrite;
    assign rd    = psel & penable & ~pwrite;
    assign setup = psel & ~penable;
    assign hit   = paddr inside {sspt_pkg::OFS_BUF, sspt_pkg::OFS_CON1,
                                 sspt_pkg::OFS_STAT, sspt_pkg::OFS_CON2,
                                 sspt_pkg::OFS_ADDR, sspt_pkg::OFS_PIR,
                                 sspt_pkg::OFS_PIE, sspt_pkg::OFS_IPR};
    assign slv    = q.en & (q.mode inside {sspt_pkg::MODE_S7, sspt_pkg::MODE_S10,
                                           sspt_pkg::MODE_S7I, sspt_pkg::MODE_S10I});
    assign ten    = q.mode inside {sspt_pkg::MODE_S10, sspt_pkg::MODE_S10I};
    assign sp_irq = q.mode inside {sspt_pkg::MODE_S7I, sspt_pkg::MODE_S10I};
    // Firmware master leaves the engine idle; software drives the pins elsewhere
    assign mst    = q.en & (q.mode == sspt_pkg::MODE_MST);
    assign mbusy  = (q.ms != sspt_pkg::M_IDLE) | (|q.con2[sspt_pkg::C2_ACK_SEQUENCE_REQUEST:0]);
    // Sleep stops the rate generator, which freezes the master mid-bit;
    // idle power states leave sleep low, so transfers run on at the clock given
    assign tick   = mst & ~sleep & (q.brg == 7'h00);

    assign rise  = scl_s & ~q.sclp;
    assign fall  = ~scl_s & q.sclp;
    assign start = scl_s & q.sclp & q.sdap & ~sda_s;
    assign stop  = scl_s & q.sclp & ~q.sdap & sda_s;

    always_comb begin
        case (paddr)
            sspt_pkg::OFS_BUF:  rmux = q.buf_r;
            sspt_pkg::OFS_CON1: rmux = {q.write_collision, q.ov, q.en, q.clock_polarity, q.mode};
            sspt_pkg::OFS_STAT: rmux = {q.slew_select, q.cke, q.da, q.p, q.s, q.rw, q.ua, q.bf};
            sspt_pkg::OFS_CON2: rmux = q.con2;
            sspt_pkg::OFS_ADDR: rmux = q.addr;
            sspt_pkg::OFS_PIR:  rmux = {4'h0, q.pirf, 3'h0};
            sspt_pkg::OFS_PIE:  rmux = q.pie;
            sspt_pkg::OFS_IPR:  rmux = q.ipr;
            default:            rmux = 8'h00;
        endcase
    end

    // ****************************************
    // Next state: software side first, hardware events after so they win
    // ****************************************
    always_comb begin
        logic acc, hi, hit7, hitx, part;
        n    = q;
        acc  = ~q.bf & ~q.ov;
        hi   = (q.sr[7:3] == sspt_pkg::TEN_HDR) & (q.sr[2:1] == q.addr[2:1]);
        hit7 = (q.sr[7:1] == q.addr[7:1])
             | (q.con2[sspt_pkg::C2_GCEN] & (q.sr[7:1] == sspt_pkg::GEN_CALL));
        hitx = ten ? ((q.th & hi & q.sr[0]) | (q.th & ~q.sr[0] & (q.sr == q.addr)))
                   : hit7;
        part = ten & hi & ~q.sr[0] & ~q.th;
        if (setup) begin
            n.rd = rmux;
        end
        if (wr) begin
            case (paddr)
                sspt_pkg::OFS_BUF: begin
                    if ((mst & mbusy) | (slv & q.stx & (q.bitc != 4'h0))) begin
                        n.write_collision = 1'b1;
                    end else begin
                        n.buf_r = wd;
                        n.sr    = wd;
                        n.bf    = 1'b1;
                        if (mst) begin
                            n.ms   = sspt_pkg::M_TX;
                            n.rw   = 1'b1;
                            n.bitc = 4'h0;
                            n.ph   = 2'h0;
                        end
                        if (slv & q.stx) begin
                            n.sdl = ~wd[7];
                        end
                    end
                end
                sspt_pkg::OFS_CON1: {n.write_collision, n.ov, n.en, n.clock_polarity, n.mode} = wd;
                sspt_pkg::OFS_STAT: {n.slew_select, n.cke} = wd[7:6];
                // Requests cannot be queued while the master is active
                sspt_pkg::OFS_CON2: n.con2 = mbusy ? {wd[7:5], q.con2[4:0]} : wd;
                sspt_pkg::OFS_ADDR: begin
                    n.addr = wd;
                    n.ua   = 1'b0;
                end
                sspt_pkg::OFS_PIR: n.pirf = wd[sspt_pkg::PIR_PORT];
                sspt_pkg::OFS_PIE: n.pie  = wd;
                sspt_pkg::OFS_IPR: n.ipr  = wd;
                default: ;
            endcase
        end
        if (rd && paddr == sspt_pkg::OFS_BUF) begin
            n.bf = 1'b0;
        end
        n.sclp = scl_s;
        n.sdap = sda_s;
        if (!n.en) begin
            n.p    = 1'b0;
            n.s    = 1'b0;
            n.ms   = sspt_pkg::M_IDLE;
            n.msl  = 1'b0;
            n.mdl  = 1'b0;
            n.sdl  = 1'b0;
            n.lis  = 1'b0;
            n.sact = 1'b0;
            n.stx  = 1'b0;
            n.th   = 1'b0;
            n.bitc = 4'h0;
            n.ph   = 2'h0;
        end else if (start) begin
            // Build on n so a software access in the same cycle is not undone
            n.s    = 1'b1;
            n.p    = 1'b0;
            n.rw   = mst ? n.rw : 1'b0;
            n.lis  = slv;
            n.sact = 1'b0;
            n.stx  = 1'b0;
            n.sdl  = 1'b0;
            n.bitc = slv ? 4'h0 : n.bitc;
            n.pirf = n.pirf | (slv & sp_irq);
        end else if (stop) begin
            n.p    = 1'b1;
            n.s    = 1'b0;
            n.rw   = mst ? n.rw : 1'b0;
            n.lis  = 1'b0;
            n.sact = 1'b0;
            n.stx  = 1'b0;
            n.th   = 1'b0;
            n.sdl  = 1'b0;
            n.pirf = n.pirf | (slv & sp_irq);
        end else if (slv && q.lis) begin
            if (rise) begin
                if (q.bitc < sspt_pkg::ACK_BIT) begin
                    n.sr   = q.stx ? {q.sr[6:0], 1'b0} : {q.sr[6:0], sda_s};
                    n.bitc = q.bitc + 4'h1;
                end else if (q.bitc == sspt_pkg::ACK_BIT) begin
                    n.bitc = sspt_pkg::END_BIT;
                    if (q.stx && sda_s) begin
                        n.lis  = 1'b0;
                        n.sact = 1'b0;
                        n.stx  = 1'b0;
                        n.rw   = 1'b0;
                    end
                end
            end else if (fall) begin
                if (q.bitc < sspt_pkg::ACK_BIT) begin
                    n.sdl = q.stx & ~q.sr[7];
                end else if (q.bitc == sspt_pkg::ACK_BIT && q.stx) begin
                    n.sdl = 1'b0;
                    n.bf  = 1'b0;
                end else if (q.bitc == sspt_pkg::ACK_BIT && !q.sact) begin
                    if (hitx | part) begin
                        n.sdl  = acc;
                        n.buf_r = acc ? q.sr : q.buf_r;
                        n.bf   = 1'b1;
                        n.ov   = n.ov | ~acc;
                        n.pirf = 1'b1;
                        n.da   = 1'b0;
                        n.ua   = ten & ~(hi & q.sr[0]);
                        n.th   = q.th | part;
                        n.sact = hitx;
                        n.rw   = hitx & q.sr[0];
                        n.stx  = hitx & q.sr[0];
                    end else begin
                        n.lis = 1'b0;
                    end
                end else if (q.bitc == sspt_pkg::ACK_BIT) begin
                    n.da   = 1'b1;
                    n.pirf = 1'b1;
                    n.sdl  = acc;
                    n.buf_r = acc ? q.sr : q.buf_r;
                    n.bf   = 1'b1;
                    n.ov   = n.ov | ~acc;
                end else if (q.bitc == sspt_pkg::END_BIT) begin
                    n.bitc = 4'h0;
                    n.sdl  = q.stx & ~q.sr[7];
                    // Stretch after each acked sent byte until software sets the clock polarity bit again
                    n.clock_polarity  = q.stx ? 1'b0 : n.clock_polarity;
                end
            end
        end
        if (mst && !sleep) begin
            n.brg = tick ? q.addr[6:0] : q.brg - 7'h01;
        end
        if (tick) begin
            n.ph = q.ph + 2'h1;
            case (q.ms)
                sspt_pkg::M_IDLE: begin
                    n.ph   = 2'h0;
                    n.bitc = 4'h0;
                    if (q.con2[sspt_pkg::C2_SEN]) n.ms = sspt_pkg::M_START;
                    else if (q.con2[sspt_pkg::C2_RESTART_REQUEST]) n.ms = sspt_pkg::M_RSTART;
                    else if (q.con2[sspt_pkg::C2_PEN]) n.ms = sspt_pkg::M_STOP;
                    else if (q.con2[sspt_pkg::C2_RECEIVE_REQUEST]) n.ms = sspt_pkg::M_RX;
                    else if (q.con2[sspt_pkg::C2_ACK_SEQUENCE_REQUEST]) n.ms = sspt_pkg::M_ACK;
                end
                sspt_pkg::M_START: begin
                    if (q.ph == 2'h0) n.mdl = 1'b1;
                    else begin
                        n.msl = 1'b1;
                        n.con2[sspt_pkg::C2_SEN] = 1'b0;
                        n.ms = sspt_pkg::M_IDLE;
                    end
                end
                sspt_pkg::M_RSTART: begin
                    if (q.ph == 2'h0) n.mdl = 1'b0;
                    if (q.ph == 2'h1) n.msl = 1'b0;
                    if (q.ph == 2'h2) n.mdl = 1'b1;
                    if (q.ph == 2'h3) begin
                        n.msl = 1'b1;
                        n.con2[sspt_pkg::C2_RESTART_REQUEST] = 1'b0;
                        n.ms = sspt_pkg::M_IDLE;
                    end
                end
                sspt_pkg::M_STOP: begin
                    if (q.ph == 2'h0) n.mdl = 1'b1;
                    if (q.ph == 2'h1) n.msl = 1'b0;
                    if (q.ph == 2'h2) n.mdl = 1'b0;
                    if (q.ph == 2'h3) begin
                        n.con2[sspt_pkg::C2_PEN] = 1'b0;
                        n.ms = sspt_pkg::M_IDLE;
                    end
                end
                sspt_pkg::M_ACK: begin
                    if (q.ph == 2'h0) n.mdl = ~q.con2[sspt_pkg::C2_ACKDT];
                    if (q.ph == 2'h1) n.msl = 1'b0;
                    if (q.ph == 2'h3) begin
                        n.msl = 1'b1;
                        n.con2[sspt_pkg::C2_ACK_SEQUENCE_REQUEST] = 1'b0;
                        n.ms = sspt_pkg::M_IDLE;
                    end
                end
                sspt_pkg::M_TX: begin
                    if (q.ph == 2'h0) n.mdl = (q.bitc < sspt_pkg::ACK_BIT) & ~q.sr[7];
                    if (q.ph == 2'h1) n.msl = 1'b0;
                    if (q.ph == 2'h2 && q.bitc == sspt_pkg::ACK_BIT) begin
                        n.con2[sspt_pkg::C2_ACKST] = sda_s;
                    end
                    if (q.ph == 2'h3) begin
                        n.msl = 1'b1;
                        if (q.bitc == sspt_pkg::ACK_BIT) begin
                            n.rw = 1'b0;
                            n.bf = 1'b0;
                            n.ms = sspt_pkg::M_IDLE;
                        end else begin
                            n.sr   = {q.sr[6:0], 1'b0};
                            n.bitc = q.bitc + 4'h1;
                        end
                    end
                end
                sspt_pkg::M_RX: begin
                    if (q.ph == 2'h0) n.mdl = 1'b0;
                    if (q.ph == 2'h1) n.msl = 1'b0;
                    if (q.ph == 2'h2) n.sr = {q.sr[6:0], sda_s};
                    if (q.ph == 2'h3) begin
                        n.msl  = 1'b1;
                        n.bitc = q.bitc + 4'h1;
                        if (q.bitc == sspt_pkg::LAST_BIT) begin
                            n.buf_r = q.bf ? q.buf_r : q.sr;
                            n.ov = n.ov | q.bf;
                            n.bf = 1'b1;
                            n.con2[sspt_pkg::C2_RECEIVE_REQUEST] = 1'b0;
                            n.ms = sspt_pkg::M_IDLE;
                        end
                    end
                end
                default: n.ms = sspt_pkg::M_IDLE;
            endcase
            // Every completed master step raises the port flag
            if (q.ms != sspt_pkg::M_IDLE && n.ms == sspt_pkg::M_IDLE) begin
                n.pirf = 1'b1;
                n.ph   = 2'h0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q      <= '0;
            // Pin history starts at the idle level so release shows no false edge
            q.sclp <= sspt_pkg::BUS_IDLE;
            q.sdap <= sspt_pkg::BUS_IDLE;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata  = {24'h000000, q.rd};
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    // Pins are driven only low; the port relies on the directions set as inputs
    assign scl_o   = 1'b0;
    assign sda_o   = 1'b0;
    assign scl_oe  = q.msl | (slv & q.sact & ~q.clock_polarity & (q.bitc == 4'h0));
    assign sda_oe  = q.mdl | q.sdl;
    assign wake    = q.pirf & q.pie[sspt_pkg::PIR_PORT];
    assign bus_active = q.rw | (|q.con2[sspt_pkg::C2_ACK_SEQUENCE_REQUEST:0]);
    assign shift_bus_mode = {q.clock_polarity, ~q.cke};

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_buf_wr;
        psel && penable && pwrite && paddr == sspt_pkg::OFS_BUF;
    endsequence
    sequence s_rx_last;
        tick && q.ms == sspt_pkg::M_RX && q.ph == 2'h3 && q.bitc == sspt_pkg::LAST_BIT;
    endsequence

    AST_BUF_LOAD: assert property (s_buf_wr ##0 !mbusy && !slv |=>
        q.buf_r == $past(pwdata[7:0]) && q.sr == $past(pwdata[7:0]) && q.bf)
        else $error("buffer write did not load buffer and shift register");
    AST_WRITE_COLLISION: assert property (s_buf_wr ##0 (mst && mbusy) |=> q.write_collision)
        else $error("collision not flagged");
    AST_RX_DONE: assert property (s_rx_last |=> q.bf && q.pirf && !q.con2[3])
        else $error("received byte not delivered");
    AST_STAT_WR: assert property (psel && penable && pwrite
        && paddr == sspt_pkg::OFS_STAT |=> {q.slew_select, q.cke} == $past(pwdata[7:6]))
        else $error("status upper bits not writable");
    AST_DISABLE: assert property (!q.en |-> !q.p && !q.s && q.ms == sspt_pkg::M_IDLE)
        else $error("disabled port keeps bus state");
    AST_START: assert property (q.en && start |=> q.s && !q.p)
        else $error("start not recorded");
    AST_SLEEP: assert property (sleep && mst && q.ms != sspt_pkg::M_IDLE
        |=> $stable(q.ms) && $stable(q.ph) && $stable(q.brg))
        else $error("master moved during sleep");
    AST_BRG: assert property (tick |=> q.brg == $past(q.addr[6:0]))
        else $error("rate generator reload wrong");
    AST_WAKE: assert property ($rose(q.pirf) && q.pie[3] |-> wake)
        else $error("wake missing");
    AST_BUSY: assert property (s_buf_wr ##0 (mst && !mbusy) |=> bus_active [*2])
        else $error("transmit not shown busy");
    AST_MODE: assert property (!q.clock_polarity && q.cke |-> shift_bus_mode == 2'h0)
        else $error("shift mode mapping wrong");

endmodule

// >>> sim/sspt_peer.sv
// Bus peer for the two-wire port: pulled-up lines and a receiver that acks.
// Assumes the port is the only clock source and only ever pulls lines low.
`timescale 1ns/1ps
module sspt_peer (
    input  wire logic       rst,
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    output logic            scl,
    output logic            sda,
    output logic [7:0]      got,
    output logic [3:0]      bits
);
    logic pull_q;
    // Released lines float up to the pull-up level
    assign scl = ~scl_oe;
    assign sda = ~(sda_oe | pull_q);
    always @(posedge scl or posedge rst) begin
        if (rst) begin
            bits <= 4'h0;
            got  <= 8'h00;
        end else if (bits == 4'h8) begin
            bits <= 4'h0;
        end else begin
            got  <= {got[6:0], sda};
            bits <= bits + 4'h1;
        end
    end
    // Ack driven from the fall after the eighth bit to the next fall
    always @(negedge scl or posedge rst) begin
        if (rst) pull_q <= 1'b0;
        else pull_q <= (bits == 4'h8);
    end
endmodule

// >>> sim/test_sync_serial_port_two_wire.sv
// Self-checking bench of the two-wire port: APB tasks and sequences of calls.
// Assumes the port answers APB at once and the peer acks every byte.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module test_sync_serial_port_two_wire;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sleep = 1'b0, pslverr, pready, wake, bus_active, scl, sda;
    logic scl_o, sda_o, scl_oe, sda_oe, err;
    logic [7:0]  paddr = 8'h00, got;
    logic [3:0]  bits, b0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0]  shift_bus_mode;
    int          error_cnt = 0, tests_run = 0, i;
    sspt_core u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .sleep(sleep), .wake(wake), .bus_active(bus_active),
        .shift_bus_mode(shift_bus_mode));
    sspt_peer u_peer (.rst(rst), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl),
        .sda(sda), .got(got), .bits(bits));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // A non-zero request clears the port flag, issues the step and waits for it
    task automatic wait_done(input logic [31:0] c2);
        if (c2 != 32'h0) begin
            apb(1'b1, sspt_pkg::OFS_PIR, 32'h0);
            apb(1'b1, sspt_pkg::OFS_CON2, c2);
        end
        for (i = 0; i < 300; i++) begin
            apb(1'b0, sspt_pkg::OFS_PIR, 32'h0);
            if (q[sspt_pkg::PIR_PORT] === 1'b1) break;
        end
        `CHK(q[sspt_pkg::PIR_PORT], 1'b1)
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q, 32'h0)
        `CHK(shift_bus_mode, 2'b01)
        apb(1'b1, sspt_pkg::OFS_STAT, 32'hff);
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q, 32'hc0)
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, sspt_pkg::OFS_CON1, m[1] ? 32'h10 : 32'h00);
            apb(1'b1, sspt_pkg::OFS_STAT, m[0] ? 32'h00 : 32'h40);
            @(posedge clk); `CHK(shift_bus_mode, 2'(m))
        end
        apb(1'b1, sspt_pkg::OFS_CON2, 32'h80);
        apb(1'b0, sspt_pkg::OFS_CON2, 32'h0); `CHK(q, 32'h80)
        apb(1'b1, sspt_pkg::OFS_ADDR, 32'h01);
        apb(1'b0, sspt_pkg::OFS_ADDR, 32'h0); `CHK(q, 32'h01)
        apb(1'b0, 8'h20, 32'h0); `CHK({err, q}, 33'h100000000)
        $display("test registers done");
        // Clear status and controls, then enable master with baud reload 1
        apb(1'b1, sspt_pkg::OFS_STAT, 32'h0);
        apb(1'b1, sspt_pkg::OFS_CON2, 32'h0);
        apb(1'b1, sspt_pkg::OFS_PIE, 32'h08);
        apb(1'b1, sspt_pkg::OFS_CON1, {28'h2, sspt_pkg::MODE_MST});
        // A start first, so the clock is held low before the first data bit
        wait_done(32'h01);
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q[4:3], 2'b01)
        apb(1'b1, sspt_pkg::OFS_PIR, 32'h0);
        apb(1'b1, sspt_pkg::OFS_BUF, 32'ha5);
        apb(1'b1, sspt_pkg::OFS_BUF, 32'h3c);
        apb(1'b0, sspt_pkg::OFS_CON1, 32'h0); `CHK(q, 32'ha8)
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q[2:0], 3'b101)
        `CHK(bus_active, 1'b1)
        sleep <= 1'b1;
        repeat (3) @(posedge clk);
        b0 = bits;
        repeat (40) @(posedge clk);
        `CHK(bits, b0)
        sleep <= 1'b0;
        wait_done(32'h0);
        `CHK(got, 8'ha5)
        `CHK(wake, 1'b1)
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q[2:0], 3'b000)
        apb(1'b0, sspt_pkg::OFS_CON2, 32'h0); `CHK(q[6], 1'b0)
        apb(1'b1, sspt_pkg::OFS_CON1, 32'h28);
        apb(1'b0, sspt_pkg::OFS_CON1, 32'h0); `CHK(q, 32'h28)
        $display("test master transmit done");
        // Peer leaves the data line released, so every received bit is one
        wait_done(32'h08);
        apb(1'b0, sspt_pkg::OFS_BUF, 32'h0); `CHK(q, 32'hff)
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q[0], 1'b0)
        // Acknowledge ends with data low, so the stop shows a rising data edge
        wait_done(32'h10);
        wait_done(32'h04);
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q[4:3], 2'b10)
        apb(1'b1, sspt_pkg::OFS_CON1, 32'h08);
        apb(1'b0, sspt_pkg::OFS_STAT, 32'h0); `CHK(q[4:3], 2'b00)
        $display("test receive, stop and disable done");
        apb(1'b1, sspt_pkg::OFS_CON1, 32'h28);
        apb(1'b1, sspt_pkg::OFS_BUF, 32'h5a);
        repeat (12) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        `CHK({scl_o, sda_o, scl_oe, sda_oe, bus_active}, 5'b00000)
        apb(1'b0, sspt_pkg::OFS_CON1, 32'h0); `CHK(q, 32'h0)
        $display("test reset abort done");
        close_out();
    end
endmodule
